// ===== common/arlc_pkg.sv
// Shared constants and types for the alarm relay and link configuration block.
package arlc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int INHIBIT_S = 60;
  localparam int IDLE_S = 300;
  localparam int CAL_DELAY_S = 30;
  localparam int BAUD = 9600;
  localparam int GAP_TENTHS = 35;
  localparam int CNT_W = 33;
  localparam logic [32:0] INHIBIT_CYC = 33'(longint'(INHIBIT_S) * CLK_HZ);
  localparam logic [32:0] IDLE_CYC = 33'(longint'(IDLE_S) * CLK_HZ);
  localparam logic [32:0] CAL_CYC = 33'(longint'(CAL_DELAY_S) * CLK_HZ);
  localparam logic [15:0] BIT_CYC = 16'(CLK_HZ / BAUD);
  localparam logic [19:0] GAP_CYC = 20'((CLK_HZ / BAUD) * GAP_TENTHS);
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_THR1 = 8'h08;
  localparam logic [7:0] REG_THR2 = 8'h0C;
  localparam logic [7:0] REG_CALT = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [15:0] THR_RST = 16'hFFFF;
  localparam logic [15:0] CALT_RST = 16'h0000;
  localparam logic [15:0] HYST_DIV = 16'h000A;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] DATA_BYTES = 8'h04;
  localparam logic [3:0] RESP_LEN = 4'h9;
  localparam logic [3:0] CRC_LAST = 4'h6;
  localparam logic [3:0] MIN_FRAME = 4'h4;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [3:0] STOP_BIT = 4'h9;
  typedef struct packed {
    logic cal_auto;
    logic fault_pol;
    logic [1:0] fail_safe;
    logic [1:0] latching;
  } arlc_cfg_type;
  localparam arlc_cfg_type CFG_RST = 6'h00;
  typedef struct packed {
    logic inc;
    logic dec;
    logic menu;
    logic op_reset;
  } arlc_btn_type;
  typedef enum logic [3:0] {
    SCR_OFF, SCR_LATCH1, SCR_LATCH2, SCR_FS1, SCR_FS2, SCR_FAULT, SCR_CAL, SCR_ADDR, SCR_BAUD
  } arlc_screen_type;
  typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} arlc_uart_type;
endpackage : arlc_pkg

// ===== core/arlc_top.sv
// Alarm relay controller, settings menu and serial-bus server.
//
// Operation
// - Non-latching relay releases when gas drops.
// - Latching relay holds until operator reset.
// - Non-latching release needs ten percent below threshold.
// - Latch reset ignored unless gas below threshold.
// - Alarms suppressed one minute after menu exit.
// - Restore sets both relays non-latching.
// - Latch screens toggle, menu stores and advances.
// - Fail-safe relay energized idle, off in alarm.
// - Fail-safe defaults to disabled.
// - Fault output polarity selectable, default de-asserts.
// - Increment manual, decrement automatic, manual default.
// - Auto calibration forces target after delay.
// - Answer only frames addressed to us.
// - Server address kept within 1 to 247.
// - Characters are 8 data, no parity, 1 stop.
// - Float response bytes sent least significant first.
// - Restore sets server address to 1.
// - Address screen raises, lowers, stores and advances.
// - Five idle minutes close the menu.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module arlc_top #(
  parameter logic [32:0] INHIBIT_CYC = arlc_pkg::INHIBIT_CYC,
  parameter logic [32:0] IDLE_CYC = arlc_pkg::IDLE_CYC,
  parameter logic [32:0] CAL_CYC = arlc_pkg::CAL_CYC,
  parameter logic [19:0] GAP_CYC = arlc_pkg::GAP_CYC,
  parameter logic [15:0] BIT_CYC = arlc_pkg::BIT_CYC
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Wishbone slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Front panel.
  input wire arlc_pkg::arlc_btn_type BTN,
  input wire logic MENU_ENTER,
  input wire logic RESTORE,
  // Measurement and fault.
  input wire logic [15:0] GAS_LEVEL,
  input wire logic [31:0] GAS_FLOAT,
  input wire logic FAULT_IN,
  input wire logic CAL_START,
  // Outputs.
  output logic [1:0] RELAY_DRIVE,
  output logic FAULT_OUT,
  output logic CAL_FORCE,
  output logic [15:0] CAL_VALUE,
  output logic MENU_OPEN,
  output logic INHIBIT,
  // Serial link.
  input wire logic RS485_RX,
  output logic RS485_TX,
  output logic RS485_TX_EN
);
  arlc_pkg::arlc_cfg_type cfg_reg;
  arlc_pkg::arlc_screen_type scr_reg;
  arlc_pkg::arlc_uart_type rx_st_reg;
  logic [7:0] addr_reg;
  logic [15:0] thr_reg [2];
  logic [15:0] calt_reg;
  logic [7:0] edit_reg;
  logic [32:0] idle_reg;
  logic [32:0] inh_reg;
  logic [32:0] cal_reg;
  logic exit_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic fault_reg;
  logic [1:0] alarm;
  logic [1:0] relay;
  logic commit;
  logic timeout;
  logic wb_wr;
  logic [15:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_byte_reg;
  logic [19:0] gap_reg;
  logic [3:0] flen_reg;
  logic fmatch_reg;
  logic [15:0] fcrc_reg;
  logic tx_start;
  logic tx_busy_reg;
  logic [3:0] tx_idx_reg;
  logic [3:0] tx_bit_reg;
  logic [15:0] tx_cnt_reg;
  logic [9:0] tx_sh_reg;
  logic [15:0] tx_crc_reg;
  logic [31:0] flt_reg;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ arlc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [7:0] clamp_addr(input logic [7:0] a);
    if (a < arlc_pkg::ADDR_MIN) begin
      return arlc_pkg::ADDR_MIN;
    end
    return (a > arlc_pkg::ADDR_MAX) ? arlc_pkg::ADDR_MAX : a;
  endfunction : clamp_addr

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge16

  function automatic logic [7:0] load_edit(input arlc_pkg::arlc_screen_type s,
                                           input arlc_pkg::arlc_cfg_type c, input logic [7:0] a);
    case (s)
      arlc_pkg::SCR_LATCH1: return {7'h00, c.latching[0]};
      arlc_pkg::SCR_LATCH2: return {7'h00, c.latching[1]};
      arlc_pkg::SCR_FS1: return {7'h00, c.fail_safe[0]};
      arlc_pkg::SCR_FS2: return {7'h00, c.fail_safe[1]};
      arlc_pkg::SCR_FAULT: return {7'h00, c.fault_pol};
      arlc_pkg::SCR_CAL: return {7'h00, c.cal_auto};
      arlc_pkg::SCR_ADDR: return a;
      default: return 8'h00;
    endcase
  endfunction : load_edit

  function automatic logic [7:0] edit_step(input arlc_pkg::arlc_screen_type s,
                                           input logic [7:0] e, input logic up);
    case (s)
      arlc_pkg::SCR_LATCH1, arlc_pkg::SCR_LATCH2: return {7'h00, ~e[0]};
      arlc_pkg::SCR_FS1, arlc_pkg::SCR_FS2, arlc_pkg::SCR_FAULT: return {7'h00, up};
      arlc_pkg::SCR_CAL: return {7'h00, ~up};
      arlc_pkg::SCR_ADDR: return up ? clamp_addr(e + 8'h01) : clamp_addr(e - 8'h01);
      default: return e;
    endcase
  endfunction : edit_step

  function automatic logic [7:0] resp_byte(input logic [3:0] i, input logic [7:0] a,
                                           input logic [31:0] f, input logic [15:0] c);
    case (i)
      4'h0: return a;
      4'h1: return arlc_pkg::FUNC_READ;
      4'h2: return arlc_pkg::DATA_BYTES;
      4'h3: return f[7:0];
      4'h4: return f[15:8];
      4'h5: return f[23:16];
      4'h6: return f[31:24];
      4'h7: return c[7:0];
      default: return c[15:8];
    endcase
  endfunction : resp_byte

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // Wishbone slave answers one cycle after the request; writes land on the ack edge.
  assign wb_wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
      case (WB_ADR_I)
        arlc_pkg::REG_CTRL: dat_reg <= {26'h0, cfg_reg};
        arlc_pkg::REG_ADDR: dat_reg <= {24'h0, addr_reg};
        arlc_pkg::REG_THR1: dat_reg <= {16'h0, thr_reg[0]};
        arlc_pkg::REG_THR2: dat_reg <= {16'h0, thr_reg[1]};
        arlc_pkg::REG_CALT: dat_reg <= {16'h0, calt_reg};
        arlc_pkg::REG_STAT: dat_reg <= {24'h0, 4'(scr_reg), INHIBIT, MENU_OPEN, alarm};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Menu walks the setting screens; edits stay local until the menu button commits them.
  assign timeout = (scr_reg != arlc_pkg::SCR_OFF) && (idle_reg >= IDLE_CYC - 33'h1);
  assign commit = BTN.menu && (scr_reg != arlc_pkg::SCR_OFF) && !timeout;
  assign MENU_OPEN = (scr_reg != arlc_pkg::SCR_OFF);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      scr_reg <= arlc_pkg::SCR_OFF;
      edit_reg <= 8'h00;
      idle_reg <= 33'h0;
      exit_reg <= 1'b0;
    end else begin
      exit_reg <= 1'b0;
      if (scr_reg == arlc_pkg::SCR_OFF) begin
        idle_reg <= 33'h0;
        if (MENU_ENTER) begin
          scr_reg <= arlc_pkg::SCR_LATCH1;
          edit_reg <= load_edit(arlc_pkg::SCR_LATCH1, cfg_reg, addr_reg);
        end
      end else if (timeout) begin
        scr_reg <= arlc_pkg::SCR_OFF;
        exit_reg <= 1'b1;
      end else if (commit) begin
        idle_reg <= 33'h0;
        if (scr_reg == arlc_pkg::SCR_BAUD) begin
          scr_reg <= arlc_pkg::SCR_OFF;
          exit_reg <= 1'b1;
        end else begin
          scr_reg <= arlc_pkg::arlc_screen_type'(4'(scr_reg) + 4'h1);
          edit_reg <= load_edit(arlc_pkg::arlc_screen_type'(4'(scr_reg) + 4'h1), cfg_reg,
                                addr_reg);
        end
      end else if (BTN.inc | BTN.dec) begin
        idle_reg <= 33'h0;
        edit_reg <= edit_step(scr_reg, edit_reg, BTN.inc);
      end else begin
        idle_reg <= idle_reg + 33'h1;
      end
    end
  end

  // Stored settings; restore wins over a commit, a commit over a bus write.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST | RESTORE) begin
      cfg_reg <= arlc_pkg::CFG_RST;
      addr_reg <= arlc_pkg::ADDR_RST;
      thr_reg[0] <= arlc_pkg::THR_RST;
      thr_reg[1] <= arlc_pkg::THR_RST;
      calt_reg <= arlc_pkg::CALT_RST;
    end else if (commit) begin
      case (scr_reg)
        arlc_pkg::SCR_LATCH1: cfg_reg.latching[0] <= edit_reg[0];
        arlc_pkg::SCR_LATCH2: cfg_reg.latching[1] <= edit_reg[0];
        arlc_pkg::SCR_FS1: cfg_reg.fail_safe[0] <= edit_reg[0];
        arlc_pkg::SCR_FS2: cfg_reg.fail_safe[1] <= edit_reg[0];
        arlc_pkg::SCR_FAULT: cfg_reg.fault_pol <= edit_reg[0];
        arlc_pkg::SCR_CAL: cfg_reg.cal_auto <= edit_reg[0];
        arlc_pkg::SCR_ADDR: addr_reg <= clamp_addr(edit_reg);
        default: addr_reg <= addr_reg;
      endcase
    end else if (wb_wr) begin
      case (WB_ADR_I)
        arlc_pkg::REG_CTRL: cfg_reg <= WB_SEL_I[0] ? WB_DAT_I[5:0] : cfg_reg;
        arlc_pkg::REG_ADDR: addr_reg <= WB_SEL_I[0] ? clamp_addr(WB_DAT_I[7:0]) : addr_reg;
        arlc_pkg::REG_THR1: thr_reg[0] <= merge16(thr_reg[0], WB_DAT_I, WB_SEL_I);
        arlc_pkg::REG_THR2: thr_reg[1] <= merge16(thr_reg[1], WB_DAT_I, WB_SEL_I);
        arlc_pkg::REG_CALT: calt_reg <= merge16(calt_reg, WB_DAT_I, WB_SEL_I);
        default: calt_reg <= calt_reg;
      endcase
    end
  end

  // Post-menu inhibit counter.
  assign INHIBIT = (inh_reg != 33'h0);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      inh_reg <= 33'h0;
    end else if (exit_reg) begin
      inh_reg <= INHIBIT_CYC;
    end else if (INHIBIT) begin
      inh_reg <= inh_reg - 33'h1;
    end
  end

  // Per-relay alarm with hysteresis, latching and fail-safe drive.
  for (genvar i = 0; i < 2; i++) begin : g_rly
    logic alm_reg;
    logic drv_reg;
    logic [15:0] hyst;
    assign hyst = thr_reg[i] - (thr_reg[i] / arlc_pkg::HYST_DIV);
    assign alarm[i] = alm_reg;
    assign relay[i] = drv_reg;
    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
        alm_reg <= 1'b0;
      end else if (!alm_reg) begin
        alm_reg <= (GAS_LEVEL >= thr_reg[i]) && !INHIBIT;
      end else if (!cfg_reg.latching[i]) begin
        alm_reg <= !(GAS_LEVEL < hyst);
      end else if (BTN.op_reset && (GAS_LEVEL < thr_reg[i])) begin
        alm_reg <= 1'b0;
      end
    end
    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
        drv_reg <= 1'b0;
      end else begin
        drv_reg <= alm_reg ^ cfg_reg.fail_safe[i];
      end
    end
    a_relay_drive: assert property (##1 drv_reg == $past(alm_reg ^ cfg_reg.fail_safe[i]))
      else $error("relay drive does not follow alarm and fail-safe");
    a_latch_hold: assert property (alm_reg && cfg_reg.latching[i] && !BTN.op_reset |=> alm_reg)
      else $error("latched alarm released without reset");
    a_latch_gate: assert property (alm_reg && cfg_reg.latching[i] && GAS_LEVEL >= thr_reg[i]
      |=> alm_reg)
      else $error("latched alarm reset while gas above threshold");
    a_hyst_hold: assert property (alm_reg && !cfg_reg.latching[i] && GAS_LEVEL >= hyst
      |=> alm_reg)
      else $error("non-latching alarm released inside hysteresis");
    a_auto_release: assert property (alm_reg && !cfg_reg.latching[i] && GAS_LEVEL < hyst
      |=> !alm_reg)
      else $error("non-latching alarm failed to release");
    a_alarm_on: assert property (!alm_reg && !INHIBIT && GAS_LEVEL >= thr_reg[i] |=> alm_reg)
      else $error("alarm not raised at threshold");
    a_inhibit_block: assert property (!alm_reg && INHIBIT |=> !alm_reg)
      else $error("alarm raised during inhibit");
  end
  assign RELAY_DRIVE = relay;

  // Fault terminal polarity: low during a fault unless the option is set.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fault_reg <= 1'b1;
    end else begin
      fault_reg <= cfg_reg.fault_pol ? FAULT_IN : ~FAULT_IN;
    end
  end
  assign FAULT_OUT = fault_reg;

  // Automatic calibration timer.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cal_reg <= 33'h0;
      CAL_FORCE <= 1'b0;
      CAL_VALUE <= 16'h0000;
    end else begin
      CAL_FORCE <= (cal_reg == 33'h1);
      CAL_VALUE <= calt_reg;
      if (CAL_START && cfg_reg.cal_auto) begin
        cal_reg <= CAL_CYC;
      end else if (cal_reg != 33'h0) begin
        cal_reg <= cal_reg - 33'h1;
      end
    end
  end

  // Receiver for 8N1 characters, sampled mid-bit.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rx_st_reg <= arlc_pkg::U_IDLE;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_byte_reg <= 1'b0;
    end else begin
      rx_byte_reg <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 16'h1;
      case (rx_st_reg)
        arlc_pkg::U_IDLE: begin
          rx_cnt_reg <= 16'h0;
          if (!RS485_RX) begin
            rx_st_reg <= arlc_pkg::U_START;
          end
        end
        arlc_pkg::U_START: begin
          if (rx_cnt_reg == (BIT_CYC >> 1)) begin
            rx_cnt_reg <= 16'h0;
            rx_bit_reg <= 3'h0;
            rx_st_reg <= RS485_RX ? arlc_pkg::U_IDLE : arlc_pkg::U_DATA;
          end
        end
        arlc_pkg::U_DATA: begin
          if (rx_cnt_reg == BIT_CYC - 16'h1) begin
            rx_cnt_reg <= 16'h0;
            rx_sh_reg <= {RS485_RX, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_st_reg <= arlc_pkg::U_STOP;
            end
          end
        end
        arlc_pkg::U_STOP: begin
          if (rx_cnt_reg == BIT_CYC - 16'h1) begin
            rx_byte_reg <= RS485_RX;
            rx_st_reg <= arlc_pkg::U_IDLE;
          end
        end
        default: rx_st_reg <= arlc_pkg::U_IDLE;
      endcase
    end
  end

  // Frame gathering: address check and running CRC, closed by line silence.
  assign tx_start = (gap_reg == GAP_CYC) && (flen_reg >= arlc_pkg::MIN_FRAME) && fmatch_reg
                    && (fcrc_reg == 16'h0000) && !tx_busy_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      gap_reg <= 20'h0;
      flen_reg <= 4'h0;
      fmatch_reg <= 1'b0;
      fcrc_reg <= arlc_pkg::CRC_INIT;
    end else if (rx_byte_reg) begin
      gap_reg <= 20'h0;
      flen_reg <= (flen_reg == 4'hF) ? flen_reg : flen_reg + 4'h1;
      fcrc_reg <= crc_step(fcrc_reg, rx_sh_reg);
      if (flen_reg == 4'h0) begin
        fmatch_reg <= (rx_sh_reg == addr_reg);
      end
    end else if (gap_reg == GAP_CYC) begin
      flen_reg <= 4'h0;
      fmatch_reg <= 1'b0;
      fcrc_reg <= arlc_pkg::CRC_INIT;
    end else if (rx_st_reg == arlc_pkg::U_IDLE) begin
      gap_reg <= gap_reg + 20'h1;
    end
  end

  // Response transmitter: address, function, count, float and CRC.
  assign RS485_TX = tx_sh_reg[0];
  assign RS485_TX_EN = tx_busy_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0;
      tx_sh_reg <= 10'h3FF;
      tx_crc_reg <= arlc_pkg::CRC_INIT;
      flt_reg <= 32'h0000_0000;
    end else if (tx_start) begin
      tx_busy_reg <= 1'b1;
      tx_idx_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0;
      tx_sh_reg <= {1'b1, addr_reg, 1'b0};
      tx_crc_reg <= crc_step(arlc_pkg::CRC_INIT, addr_reg);
      flt_reg <= GAS_FLOAT;
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 16'h1;
      if (tx_cnt_reg == BIT_CYC - 16'h1) begin
        tx_cnt_reg <= 16'h0;
        tx_bit_reg <= tx_bit_reg + 4'h1;
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        if (tx_bit_reg == arlc_pkg::STOP_BIT) begin
          tx_bit_reg <= 4'h0;
          tx_idx_reg <= tx_idx_reg + 4'h1;
          if (tx_idx_reg == arlc_pkg::RESP_LEN - 4'h1) begin
            tx_busy_reg <= 1'b0;
            tx_sh_reg <= 10'h3FF;
          end else begin
            tx_sh_reg <= {1'b1, resp_byte(tx_idx_reg + 4'h1, addr_reg, flt_reg, tx_crc_reg), 1'b0};
            if (tx_idx_reg < arlc_pkg::CRC_LAST) begin
              tx_crc_reg <= crc_step(tx_crc_reg,
                                     resp_byte(tx_idx_reg + 4'h1, addr_reg, flt_reg, tx_crc_reg));
            end
          end
        end
      end
    end
  end

  sequence s_menu_exit;
    MENU_OPEN ##1 !MENU_OPEN;
  endsequence
  sequence s_frame_end;
    (gap_reg == GAP_CYC) && (flen_reg >= arlc_pkg::MIN_FRAME) && !tx_busy_reg;
  endsequence

  a_exit_inhibit: assert property (s_menu_exit |-> ##1 INHIBIT [*2])
    else $error("menu exit did not start the inhibit");
  a_addr_range: assert property (addr_reg >= 8'h01 && addr_reg <= 8'hF7)
    else $error("server address out of range");
  a_restore_def: assert property (RESTORE |=> cfg_reg == 6'h00 && addr_reg == 8'h01)
    else $error("restore did not load defaults");
  a_frame_filter: assert property (s_frame_end ##0 !fmatch_reg |=> !tx_busy_reg)
    else $error("answered a frame for another address");
  a_frame_answer: assert property (s_frame_end ##0 fmatch_reg && fcrc_reg == 16'h0000
    |=> tx_busy_reg && !RS485_TX)
    else $error("addressed frame not answered");
  a_fault_pol: assert property (!SYS_RST |=>
    FAULT_OUT == ($past(FAULT_IN) ~^ $past(cfg_reg.fault_pol)))
    else $error("fault output polarity wrong");
endmodule : arlc_top

// ===== bench/arlc_bus_client.sv
// Serial-bus client model that polls the server and collects its answer.
`timescale 1ns/1ns
module arlc_bus_client #(
  parameter int BIT_CYC = 8
) (
  // Clock.
  input wire logic clk,
  // Differential link, biased high when idle.
  output logic line_rx,
  input wire logic line_tx,
  input wire logic line_tx_en
);
  logic [8:0] rsp[$];
  initial line_rx = 1'b1;
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc
  task automatic put_byte(input logic [7:0] v);
    for (int i = 0; i < 10; i++) begin
      line_rx <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : v[i - 1]);
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : put_byte
  task automatic poll(input logic [7:0] id, input logic bad);
    logic [7:0] f[$];
    logic [15:0] c;
    f = '{id, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};
    c = crc(f) ^ {15'h0, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    @(posedge clk);
    foreach (f[i]) put_byte(f[i]);
  endtask : poll
  initial begin : collect
    logic [7:0] v;
    forever begin
      @(posedge clk);
      if (line_tx_en === 1'b1 && line_tx === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          v[i] = line_tx;
        end
        repeat (BIT_CYC) @(posedge clk);
        rsp.push_back({line_tx, v});
      end
    end
  end
endmodule : arlc_bus_client

// ===== bench/testbench.sv
// Self-checking bench for the alarm relay and link configuration block.
`timescale 1ns/1ns
module testbench;
  logic CLK_SYS = 1'b0;
  logic SYS_RST = 1'b1;
  logic WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, MENU_ENTER, RESTORE, FAULT_IN, CAL_START;
  logic FAULT_OUT, CAL_FORCE, MENU_OPEN, INHIBIT, RS485_RX, RS485_TX, RS485_TX_EN;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, GAS_FLOAT;
  logic [15:0] GAS_LEVEL, CAL_VALUE;
  logic [1:0] RELAY_DRIVE;
  arlc_pkg::arlc_btn_type BTN;
  int fail_count = 0;
  int total_checks = 0;
  arlc_top #(.INHIBIT_CYC(33'h32), .IDLE_CYC(33'hC8), .CAL_CYC(33'h14), .GAP_CYC(20'h28),
    .BIT_CYC(16'h8)) i_arlc_top (.CLK_SYS, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .BTN, .MENU_ENTER, .RESTORE, .GAS_LEVEL,
    .GAS_FLOAT, .FAULT_IN, .CAL_START, .RELAY_DRIVE, .FAULT_OUT, .CAL_FORCE, .CAL_VALUE,
    .MENU_OPEN, .INHIBIT, .RS485_RX, .RS485_TX, .RS485_TX_EN);
  arlc_bus_client #(.BIT_CYC(8)) i_arlc_bus_client (.clk(CLK_SYS), .line_rx(RS485_RX),
    .line_tx(RS485_TX), .line_tx_en(RS485_TX_EN));
  always #20 CLK_SYS = ~CLK_SYS;
  task automatic results;
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic hang;
    fail_count++;
    results();
  endtask : hang
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask : cyc
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'h3, we, a, s, d};
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
    if (n == 20)
      hang();
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(q, e);
  endtask : rd
  task automatic press(input logic [6:0] b);
    @(posedge CLK_SYS);
    {RESTORE, CAL_START, MENU_ENTER, BTN} <= b;
    @(posedge CLK_SYS);
    {RESTORE, CAL_START, MENU_ENTER, BTN} <= 7'h0;
  endtask : press
  task automatic relay(input logic [15:0] g, input logic [1:0] e);
    @(posedge CLK_SYS);
    GAS_LEVEL <= g;
    cyc(3);
    check(32'(RELAY_DRIVE), 32'(e));
  endtask : relay
  initial begin : main
    logic [6:0] seq[$];
    logic [7:0] ex[$];
    logic [15:0] c;
    logic [31:0] q;
    int n;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = 47'h0;
    {RESTORE, CAL_START, MENU_ENTER, BTN} = 7'h0;
    {GAS_LEVEL, FAULT_IN, GAS_FLOAT} = {16'h0, 1'b1, 32'h44332211};
    repeat (8) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    cyc(1);
    check(32'(FAULT_OUT), 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h1C, 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hF7);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h64);
    wr(8'h0C, 32'h64);
    relay(16'h64, 2'h3);
    rd(8'h14, 32'h3);
    relay(16'h5A, 2'h3);
    relay(16'h59, 2'h0);
    wr(8'h00, 32'h2);
    relay(16'h96, 2'h3);
    press(7'h01);
    relay(16'h0, 2'h2);
    press(7'h01);
    relay(16'h0, 2'h0);
    press(7'h10);
    press(7'h08);
    rd(8'h00, 32'h2);
    seq = '{7'h02, 7'h04, 7'h02, 7'h08, 7'h02, 7'h02, 7'h08, 7'h02, 7'h04, 7'h02, 7'h08,
      7'h02, 7'h02};
    foreach (seq[i]) press(seq[i]);
    relay(16'h96, 2'h1);
    check(32'(INHIBIT), 32'h1);
    cyc(55);
    check(32'(RELAY_DRIVE), 32'h2);
    check(32'(FAULT_OUT), 32'h1);
    rd(8'h00, 32'h35);
    rd(8'h04, 32'h6);
    relay(16'h0, 2'h0);
    press(7'h10);
    press(7'h08);
    cyc(205);
    check(32'(MENU_OPEN), 32'h0);
    rd(8'h00, 32'h35);
    wb(1'b1, 8'h10, 32'h5634, 4'h1, q);
    wb(1'b1, 8'h10, 32'h1299, 4'h2, q);
    press(7'h20);
    n = 0;
    while (CAL_FORCE !== 1'b1 && n < 40) begin
      @(posedge CLK_SYS);
      n++;
    end
    check(32'(n > 18 && n < 26), 32'h1);
    check(32'(CAL_VALUE), 32'h1234);
    i_arlc_bus_client.poll(8'h06, 1'b0);
    n = 0;
    while (i_arlc_bus_client.rsp.size() < 9 && n < 3000) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n == 3000)
      hang();
    ex = '{8'h06, 8'h03, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
    c = i_arlc_bus_client.crc(ex);
    ex.push_back(c[7:0]);
    ex.push_back(c[15:8]);
    foreach (ex[i]) check(32'(i_arlc_bus_client.rsp[i]), {23'h0, 1'b1, ex[i]});
    cyc(100);
    i_arlc_bus_client.poll(8'h06, 1'b1);
    cyc(100);
    i_arlc_bus_client.poll(8'h07, 1'b0);
    cyc(2000);
    check(32'(i_arlc_bus_client.rsp.size()), 32'h9);
    press(7'h40);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    FAULT_IN <= 1'b0;
    cyc(2);
    check(32'(FAULT_OUT), 32'h1);
    results();
  end
endmodule : testbench
